/* design/hbc_ctrl.sv */
// Function
// R1: Driver frees sync-fault line itself after soft shutdown; no clear pulse needed.
// R2: Controller never raises fault-clear while sync-fault line is active; only the run-state pulse checks it, supply loss raises it regardless.
// R3: Fault-clear held high stops fault latching; controller only pulses it in run state and holds it high through supply wait and start-up.
// R4: Controller holds fault-clear high at power-up until supplies are stable.
// R5: Start-up order: supply, clear high, low input high, low input low, clear low.
// R6: Low input and fault-clear start-up pulses last at least 15 us.
// R7: Driver runs normally only after start-up finishes; commands gated until then.
// R8: Driver outputs follow logic inputs in normal operation.
// R9: Driver inserts dead time; both inputs high gives both outputs low; the driver model inserts no dead time.
// R10: Pulling fault/shutdown line low forces driver outputs low.
// R11: Hard shutdown is not latched; outputs resume when line is released.
// R12: Fault/shutdown line is wired-OR, open-drain, shared by all parties.
// R13: Low supply undervoltage pulls fault/shutdown line low while it lasts.
// R14: Low supply undervoltage forces both driver outputs off.
// R15: Low supply undervoltage fault is not latched.
// R16: Floating supply undervoltage disables high side only, no diagnostic.
// R17: Floating supply undervoltage latches high output low until recovered.
// R18: High output needs fresh high input rising edge after recovery.
// R19: Active sync-fault line freezes driver outputs and ignores inputs; the driver model freezes only the low output.
// R20: Desaturation latches fault/shutdown low until a fault-clear pulse.
// R21: Soft shutdown drives sync-fault line low until it ends.
// R22: Soft shutdown masks undervoltage and external shutdown.
// R23: Pin inputs pass two-stage synchronizers; reset drives outputs off.
module hbc_ctrl (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic supply_ok_i,
  input  wire logic cmd_high_i,
  input  wire logic cmd_low_i,
  input  wire logic cmd_shutdown_i,
  input  wire logic cmd_fault_clear_i,
  input  wire logic fault_shutdown_line_i,
  input  wire logic sync_fault_line_i,
  output logic      high_in_o,
  output logic      low_in_o,
  output logic      fault_clear_input_o,
  output logic      fault_shutdown_line_o,
  output logic      fault_shutdown_line_oe_o,
  output logic      ready_o,
  output logic      fault_o,
  output logic      sync_fault_o,
  output logic      clear_busy_o
);

  // ==========================================
  // Synchronisers
  logic [1:0] fsd_sync_r;
  logic [1:0] syf_sync_r;
  logic [1:0] sup_sync_r;
  logic       fsd_low;
  logic       syf_low;
  logic       sup_ok;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fsd_sync_r <= 2'h3;
      syf_sync_r <= 2'h3;
      sup_sync_r <= 2'h0;
    end
    else
    begin
      fsd_sync_r <= {fsd_sync_r[0], fault_shutdown_line_i}; // [R23]
      syf_sync_r <= {syf_sync_r[0], sync_fault_line_i};     // [R23]
      sup_sync_r <= {sup_sync_r[0], supply_ok_i};           // [R23]
    end
  end

  assign fsd_low = ~fsd_sync_r[1];
  assign syf_low = ~syf_sync_r[1];
  assign sup_ok  = sup_sync_r[1];

  // ==========================================
  // Start-up sequencer
  hbc_pkg::hbc_state_e  state_r;
  hbc_pkg::hbc_state_e  state_nxt;
  logic [hbc_pkg::CNT_W-1:0] cnt_r;
  logic [hbc_pkg::CNT_W-1:0] cnt_nxt;
  logic                 cnt_done;
  logic                 clr_pulse_r;
  logic [hbc_pkg::CNT_W-1:0] clr_cnt_r;
  hbc_pkg::hbc_pins_s   pins_r;
  hbc_pkg::hbc_pins_s   pins_nxt;
  logic                 run;
  logic                 clr_start;
  logic                 clr_pin;

  assign cnt_done = (cnt_r == hbc_pkg::CNT_ZERO);
  assign run      = (state_r == hbc_pkg::HBC_RUN);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_done) ? cnt_r : cnt_r - 1'b1;
    case (state_r)
      hbc_pkg::HBC_WAIT_SUPPLY:
      begin
        // Clear stays high while supplies settle to mask spurious faults
        if (!sup_ok)
          cnt_nxt = hbc_pkg::SETTLE_CNT; // [R4]
        else if (cnt_done)
        begin
          state_nxt = hbc_pkg::HBC_CLR_HIGH;
          cnt_nxt   = hbc_pkg::PULSE_CNT;
        end
      end
      hbc_pkg::HBC_CLR_HIGH:
      begin
        state_nxt = hbc_pkg::HBC_CHARGE; // [R5]
        cnt_nxt   = hbc_pkg::PULSE_CNT;
      end
      hbc_pkg::HBC_CHARGE:
        if (cnt_done)
        begin
          state_nxt = hbc_pkg::HBC_LIN_LOW; // [R6]
          cnt_nxt   = hbc_pkg::PULSE_CNT;
        end
      hbc_pkg::HBC_LIN_LOW:
        if (cnt_done)
          state_nxt = hbc_pkg::HBC_CLR_LOW; // [R5]
      hbc_pkg::HBC_CLR_LOW:
        state_nxt = hbc_pkg::HBC_RUN; // [R7]
      hbc_pkg::HBC_RUN:
        if (!sup_ok)
        begin
          state_nxt = hbc_pkg::HBC_WAIT_SUPPLY;
          cnt_nxt   = hbc_pkg::SETTLE_CNT;
        end
      default:
      begin
        state_nxt = hbc_pkg::HBC_WAIT_SUPPLY;
        cnt_nxt   = hbc_pkg::SETTLE_CNT;
      end
    endcase
  end

  // ==========================================
  // Fault-clear pulse in run state
  // Refused while sync-fault is active so a soft shutdown is not disturbed
  assign clr_start = run && cmd_fault_clear_i && !clr_pulse_r && !syf_low; // [R2]
  // Pulse is finite, so latching protection stays enabled
  assign clr_pin   = run ? clr_pulse_r : (state_r != hbc_pkg::HBC_CLR_LOW); // [R3] [R4]

  always_comb
  begin
    pins_nxt.high_in           = run && cmd_high_i;       // [R8] [R7]
    pins_nxt.low_in            = (state_nxt == hbc_pkg::HBC_CHARGE) || (run && cmd_low_i); // [R5]
    pins_nxt.fault_clear_input = clr_pin;
    pins_nxt.shutdown_drive    = run && cmd_shutdown_i;   // [R10] [R11]
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r     <= hbc_pkg::HBC_WAIT_SUPPLY;
      cnt_r       <= hbc_pkg::SETTLE_CNT;
      clr_pulse_r <= 1'b0;
      clr_cnt_r   <= hbc_pkg::CNT_ZERO;
      pins_r      <= '{high_in: 1'b0, low_in: 1'b0, fault_clear_input: 1'b1, shutdown_drive: 1'b0}; // [R23]
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pins_r  <= pins_nxt;
      if (clr_start)
      begin
        clr_pulse_r <= 1'b1;
        clr_cnt_r   <= hbc_pkg::PULSE_CNT; // [R6]
      end
      else if (clr_pulse_r)
      begin
        clr_cnt_r <= clr_cnt_r - 1'b1;
        if (clr_cnt_r == hbc_pkg::CNT_ZERO)
          clr_pulse_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // Pins and status
  assign high_in_o                = pins_r.high_in;
  assign low_in_o                 = pins_r.low_in;
  assign fault_clear_input_o      = pins_r.fault_clear_input;
  // Open drain: only ever pulls low
  assign fault_shutdown_line_o    = 1'b0;                  // [R12]
  assign fault_shutdown_line_oe_o = pins_r.shutdown_drive; // [R12]
  assign ready_o                  = run;
  // Low line while not self-driven means a driver fault or low-supply undervoltage
  assign fault_o                  = fsd_low && !pins_r.shutdown_drive; // [R13] [R20]
  // Sync-fault clears itself after soft shutdown; nothing to do here
  assign sync_fault_o             = syf_low; // [R1] [R21]
  assign clear_busy_o             = clr_pulse_r;

endmodule : hbc_ctrl

/* inc/hbc_pkg.sv */
package hbc_pkg;
  // ==========================================
  // Timing
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned STARTUP_PULSE_NS = 15000;
  localparam int unsigned PULSE_CYC       = (STARTUP_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned SUPPLY_SETTLE_CYC = PULSE_CYC;
  localparam int unsigned CNT_W           = 16;
  localparam logic [CNT_W-1:0] PULSE_CNT  = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SUPPLY_SETTLE_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;

  // ==========================================
  // Sequencer states
  typedef enum logic [5:0] {
    HBC_WAIT_SUPPLY = 6'h01,
    HBC_CLR_HIGH    = 6'h02,
    HBC_CHARGE      = 6'h04,
    HBC_LIN_LOW     = 6'h08,
    HBC_CLR_LOW     = 6'h10,
    HBC_RUN         = 6'h20
  } hbc_state_e;

  // ==========================================
  // Pin bundle towards the driver
  typedef struct packed {
    logic high_in;
    logic low_in;
    logic fault_clear_input;
    logic shutdown_drive;
  } hbc_pins_s;
endpackage : hbc_pkg

/* bench/hbc_ctrl_asserts.sv */
// ========
// Checker
module hbc_ctrl_asserts (
  input wire logic clk_i, reset_i, cmd_high_i, cmd_low_i, cmd_shutdown_i, sync_fault_o, ready_o,
  input wire logic high_in_o, low_in_o, fault_clear_input_o, fault_shutdown_line_o,
  input wire logic fault_shutdown_line_oe_o, clear_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Run lengths of the two start-up pulses
  logic [15:0] lo_cnt_r, fc_cnt_r;
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      {lo_cnt_r, fc_cnt_r} <= 32'h00000000;
    else
      {lo_cnt_r, fc_cnt_r} <= {low_in_o ? lo_cnt_r + 16'h0001 : 16'h0000,
                               fault_clear_input_o ? fc_cnt_r + 16'h0001 : 16'h0000};
  lo_pulse_a: assert property ($fell(low_in_o) && !ready_o && !$past(ready_o) |-> lo_cnt_r >= hbc_pkg::PULSE_CNT)
    else $error("low pulse short");
  clr_pulse_a: assert property ($fell(fault_clear_input_o) |-> fc_cnt_r >= hbc_pkg::PULSE_CNT)
    else $error("clear pulse short");
  charge_order_a: assert property (low_in_o && !ready_o |-> fault_clear_input_o)
    else $error("charge without clear");
  run_entry_a: assert property ($rose(ready_o) |-> !fault_clear_input_o && !low_in_o)
    else $error("bad run entry");
  cmd_gate_a: assert property (!ready_o && !$past(ready_o) |-> !high_in_o && !fault_shutdown_line_oe_o)
    else $error("command before run");
  cmd_follow_a: assert property (ready_o && $past(ready_o) |->
    high_in_o == $past(cmd_high_i) && low_in_o == $past(cmd_low_i))
    else $error("inputs not passed");
  shut_pull_a: assert property (ready_o && $past(ready_o) |->
    fault_shutdown_line_oe_o == $past(cmd_shutdown_i) && !fault_shutdown_line_o)
    else $error("shutdown pull wrong");
  clr_refuse_a: assert property ($rose(clear_busy_o) |-> !$past(sync_fault_o) ##1 fault_clear_input_o)
    else $error("clear pulse wrong");
  cover property ($rose(ready_o));
  cover property ($rose(clear_busy_o));
  cover property (fault_shutdown_line_oe_o);
endmodule : hbc_ctrl_asserts

bind hbc_ctrl hbc_ctrl_asserts chk_u (.clk_i, .reset_i, .cmd_high_i, .cmd_low_i, .cmd_shutdown_i,
  .sync_fault_o, .ready_o, .high_in_o, .low_in_o, .fault_clear_input_o, .fault_shutdown_line_o,
  .fault_shutdown_line_oe_o, .clear_busy_o);

/* bench/hbc_dev_model.sv */
// ========
// Driver model, both sides; only the low output freezes during soft shutdown
module hbc_dev_model (
  input  wire logic clk_i, high_in_i, low_in_i, fclr_i, pull_i, uv_i, ssd_i, vbs_uv_i,
  output logic      line_o, sync_o, lo_o, ho_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic latch_r = 1'b0;
  logic ssd_r = 1'b0;
  logic lo_q = 1'b0, hin_q = 1'b0, ho_blk_r = 1'b0;
  always_ff @(posedge clk_i)
  begin
    ssd_r <= ssd_i;
    lo_q <= lo_o;
    hin_q <= high_in_i;
    ho_blk_r <= vbs_uv_i || (ho_blk_r && !(high_in_i && !hin_q));
    latch_r <= !fclr_i && (latch_r || (ssd_r && !ssd_i));
  end
  assign sync_o = !ssd_i;
  assign line_o = !(latch_r || (!ssd_i && (pull_i || uv_i)));
  assign lo_o = ssd_i ? lo_q : line_o && !uv_i && low_in_i && !high_in_i;
  assign ho_o = line_o && !uv_i && !ho_blk_r && high_in_i && !low_in_i;
endmodule : hbc_dev_model

/* bench/hbc_ctrl_tb.sv */
module hbc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic supply_ok_i = 1'b0, cmd_high_i = 1'b0, cmd_low_i = 1'b0, cmd_shutdown_i = 1'b0;
  logic cmd_fault_clear_i = 1'b0, dev_uv = 1'b0, dev_ssd = 1'b0, vbs_uv = 1'b0, ho;
  logic high_in_o, low_in_o, fault_clear_input_o, fault_shutdown_line_o, fault_shutdown_line_oe_o;
  logic ready_o, fault_o, sync_fault_o, clear_busy_o, line, sync_line, lo;
  int n_mismatch = 0, checked = 0, k;
  hbc_ctrl dut_u (.clk_i, .reset_i, .supply_ok_i, .cmd_high_i, .cmd_low_i, .cmd_shutdown_i,
    .cmd_fault_clear_i, .fault_shutdown_line_i(line), .sync_fault_line_i(sync_line), .high_in_o,
    .low_in_o, .fault_clear_input_o, .fault_shutdown_line_o, .fault_shutdown_line_oe_o, .ready_o,
    .fault_o, .sync_fault_o, .clear_busy_o);
  hbc_dev_model dev_u (.clk_i, .high_in_i(high_in_o), .low_in_i(low_in_o), .fclr_i(fault_clear_input_o),
    .pull_i(fault_shutdown_line_oe_o), .uv_i(dev_uv), .ssd_i(dev_ssd), .line_o(line), .sync_o(sync_line),
    .lo_o(lo), .vbs_uv_i(vbs_uv), .ho_o(ho));
  // ========
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic wait_lvl(ref logic s, input logic v);
    k = 0;
    while (s !== v && k < 3000)
    begin
      step(1);
      k++;
    end
    if (k >= 3000)
      n_mismatch++;
  endtask : wait_lvl
  task automatic chk(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // ========
  // Tests
  initial
    forever #10 clk_i = ~clk_i;
  initial
  begin
    #400000;
    n_mismatch++;
    results();
  end
  initial
  begin
    step(20);
    chk("clear_in_reset", fault_clear_input_o, 1'b1);
    reset_i = 1'b0;
    supply_ok_i = 1'b1;
    wait_lvl(low_in_o, 1'b1);
    chk("clear_in_charge", fault_clear_input_o, 1'b1);
    wait_lvl(low_in_o, 1'b0);
    chk("charge_len", k >= 750, 1'b1);
    wait_lvl(ready_o, 1'b1);
    chk("clear_in_run", fault_clear_input_o, 1'b0);
    $display("startup done");
    for (int i = 0; i < 4; i++)
    begin
      {cmd_high_i, cmd_low_i} = i[1:0];
      step(2);
      chk("high_in", high_in_o, i[1]);
      chk("low_in", low_in_o, i[0]);
      chk("drv_lo", lo, i == 1);
    end
    cmd_high_i = 1'b0;
    cmd_shutdown_i = 1'b1;
    step(3);
    chk("shut_lo", lo, 1'b0);
    chk("self_fault", fault_o, 1'b0);
    chk("od_data", fault_shutdown_line_o, 1'b0);
    cmd_shutdown_i = 1'b0;
    step(4);
    chk("resume_lo", lo, 1'b1);
    dev_uv = 1'b1;
    step(4);
    chk("uv_fault", fault_o, 1'b1);
    chk("uv_lo", lo, 1'b0);
    dev_uv = 1'b0;
    step(4);
    chk("uv_gone", fault_o, 1'b0);
    cmd_low_i = 1'b0;
    vbs_uv = 1'b1;
    cmd_high_i = 1'b1;
    step(3);
    chk("vbs_ho", ho, 1'b0);
    chk("vbs_no_diag", fault_o, 1'b0);
    vbs_uv = 1'b0;
    step(2);
    chk("vbs_latched", ho, 1'b0);
    cmd_high_i = 1'b0;
    step(2);
    cmd_high_i = 1'b1;
    step(3);
    chk("vbs_rearm", ho, 1'b1);
    cmd_high_i = 1'b0;
    cmd_low_i = 1'b1;
    step(3);
    $display("command tests done");
    dev_ssd = 1'b1;
    step(4);
    chk("sync_seen", sync_fault_o, 1'b1);
    cmd_fault_clear_i = 1'b1;
    step(2);
    chk("clear_refused", clear_busy_o, 1'b0);
    cmd_low_i = 1'b0;
    dev_uv = 1'b1;
    step(2);
    chk("frozen_lo", lo, 1'b1);
    chk("uv_masked", line, 1'b1);
    dev_uv = 1'b0;
    cmd_fault_clear_i = 1'b0;
    dev_ssd = 1'b0;
    step(4);
    chk("latched", fault_o, 1'b1);
    cmd_fault_clear_i = 1'b1;
    step(3);
    cmd_fault_clear_i = 1'b0;
    chk("clear_busy", clear_busy_o, 1'b1);
    wait_lvl(clear_busy_o, 1'b0);
    chk("fault_cleared", fault_o, 1'b0);
    $display("fault tests done");
    results();
  end
endmodule : hbc_ctrl_tb
